/* citr_pkg.sv */
// constants for the crystal interval timer and time-of-day block
// assumes an sfr port from the core and a crystal tick input on mclk
package citr_pkg;
	// sfr addresses
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'ha1;
	localparam logic [7:0] ADDR_FRACTION = 8'ha2;
	localparam logic [7:0] ADDR_ONE_HZ = 8'ha3;
	localparam logic [7:0] ADDR_SIXTY_SECOND = 8'ha4;
	localparam logic [7:0] ADDR_HOUR = 8'ha5;
	localparam logic [7:0] ADDR_INTERVAL_TARGET = 8'ha6;
	// timer_control field positions
	localparam int BIT_TIME_CLOCK_EN = 0;
	localparam int BIT_INTERVAL_EN = 1;
	localparam int BIT_MATCH_FLAG = 2;
	localparam int BIT_ONE_SHOT = 3;
	localparam int BIT_TB_LO = 4;
	localparam int BIT_TB_HI = 5;
	// reset values
	localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RST_TIME_REG = 8'h00;
	localparam logic [7:0] RST_INTERVAL_TARGET = 8'h00;
	// crystal ticks per 1/128 second step (32768 hz / 128)
	localparam int XTAL_TICKS_PER_STEP = 256;
	localparam logic [7:0] PRESCALE_LAST = 8'(XTAL_TICKS_PER_STEP - 1);
	// last value of each time stage before rollover
	localparam logic [7:0] FRACTION_LAST = 8'h7f;
	localparam logic [7:0] ONE_HZ_LAST = 8'h3b;
	localparam logic [7:0] SIXTY_SECOND_LAST = 8'h3b;
	localparam logic [7:0] HOUR_LAST = 8'h17;
	// interrupt vector reported on wake
	localparam logic [15:0] WAKE_VECTOR = 16'h0053;
	// timebase selections
	typedef enum logic [1:0] {
		citr_tb_fraction,
		citr_tb_seconds,
		citr_tb_minutes,
		citr_tb_hours
	} citr_tb_type;
endpackage : citr_pkg

/* citr_stage.sv */
// one rolling time stage: counts to a last value, wraps to zero
// assumes step is a one-cycle pulse on mclk; load and clear are exclusive
`timescale 1ns/1ps
module citr_stage #(
	parameter logic [7:0] LAST = 8'h3b
) (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic clear, // force count to zero
	input wire logic step, // advance by one
	input wire logic load, // software write strobe
	input wire logic [7:0] load_val, // software write data
	output logic [7:0] count_q, // current count
	output logic wrap // step taken at the last value
);
	import citr_pkg::*;
	logic [7:0] count_d;

	// wrap is combinational so the next stage steps in the same cycle
	assign wrap = step && (count_q == LAST);

	// next value: clear beats load beats step
	always_comb begin
		count_d = count_q;
		if (clear) begin
			count_d = 8'h00;
		end else if (load) begin
			count_d = load_val;
		end else if (wrap) begin
			count_d = 8'h00;
		end else if (step) begin
			count_d = count_q + 8'h01;
		end
	end

	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_q <= RST_TIME_REG;
		end else begin
			count_q <= count_d;
		end
	end
endmodule : citr_stage

/* citr_top.sv */
// crystal interval timer and time-of-day counter behind the sfr port
// assumes the core drives sfr strobes synchronous to mclk and the crystal
// tick arrives as a one-cycle pulse on mclk at the crystal rate
//
// Notes on behaviour
// - time base comes from crystal, not pll
// - counting continues during power-down
// - fraction counts 0..127 at 1/128 second
// - seconds count 0..59, carry to minutes
// - minutes count 0..59, carry to hours
// - hours count 0..23, then wrap to zero
// - two-bit select picks interval timebase overflow
// - counter equal to target sets match flag
// - flag plus enable requests processor interrupt
// - in power-down, flag plus enable wakes to vector 0053
// - one-shot timeout clears interval enable
// - otherwise counter reloads and runs again
// - interval enable off stops and zeroes counter
// - clock enable off stops, clears time registers
// - time registers writable while clock disabled
`timescale 1ns/1ps
module citr_top (
	input wire logic mclk, // system clock, 40 mhz
	input wire logic rst, // synchronous reset, active high
	input wire logic xtal_tick, // one pulse per crystal cycle
	input wire logic power_down, // core is in power-down
	input wire logic intv_irq_en, // interval interrupt enable from core
	input wire logic [7:0] sfr_addr, // sfr address
	input wire logic [7:0] sfr_wdata, // sfr write data
	input wire logic sfr_wr, // sfr write strobe
	input wire logic sfr_rd, // sfr read strobe
	output logic [7:0] sfr_rdata_q, // read data, one cycle after sfr_rd
	output logic irq_q, // interrupt request level
	output logic wake_q, // wake request level while powered down
	output logic [15:0] wake_vector_q // vector to resume at on wake
);
	import citr_pkg::*;

	logic [7:0] control_q, control_d;
	logic [7:0] target_q, target_d;
	logic [7:0] interval_q, interval_d;
	logic [7:0] prescale_q, prescale_d;
	logic [7:0] rdata_d;
	logic irq_d, wake_d;
	logic [15:0] vector_d;
	logic [7:0] stage_count [4];
	logic [3:0] stage_wrap;
	logic [3:0] stage_step;
	logic [3:0] stage_load;
	logic tick_step, tb_step, hit, tc_fall, wr_ctl;
	logic [7:0] interval_inc;
	citr_tb_type tb_sel;

	// address decode for the write paths; the read mux decodes sfr_addr itself
	function automatic logic is_addr(input logic [7:0] a,
			input logic [7:0] ref_a);
		is_addr = (a == ref_a);
	endfunction : is_addr

	assign tb_sel = citr_tb_type'(control_q[BIT_TB_HI:BIT_TB_LO]);
	assign wr_ctl = sfr_wr && is_addr(sfr_addr, ADDR_TIMER_CONTROL);
	// the clock enable falls only through a control write
	assign tc_fall = control_q[BIT_TIME_CLOCK_EN] &&
		!control_d[BIT_TIME_CLOCK_EN];

	// crystal prescaler: mclk never steps time, so pll changes cannot skew it
	always_comb begin
		prescale_d = prescale_q;
		if (!control_q[BIT_TIME_CLOCK_EN]) begin
			prescale_d = 8'h00;
		end else if (xtal_tick) begin
			prescale_d = prescale_q + 8'h01;
		end
	end
	// power_down is never looked at here, so time keeps running asleep
	assign tick_step = control_q[BIT_TIME_CLOCK_EN] && xtal_tick &&
		(prescale_q == PRESCALE_LAST);

	// time stages: fraction stepped by the prescaler, each other by the carry of the one below
	generate
		for (genvar i = 0; i < 4; i++) begin : g_stage
			localparam logic [7:0] LAST_V = (i == 0) ? FRACTION_LAST :
				(i == 1) ? ONE_HZ_LAST :
				(i == 2) ? SIXTY_SECOND_LAST : HOUR_LAST;
			localparam logic [7:0] ADDR_V = ADDR_FRACTION + 8'(i);
			if (i == 0) begin : g_first
				assign stage_step[i] = tick_step;
			end else begin : g_carry
				assign stage_step[i] = stage_wrap[i-1];
			end
			// writes land only while the clock is stopped
			assign stage_load[i] = sfr_wr && is_addr(sfr_addr, ADDR_V) &&
				!control_q[BIT_TIME_CLOCK_EN];
			citr_stage #(
				.LAST(LAST_V)
			) u_stage (
				.mclk(mclk),
				.rst(rst),
				.clear(tc_fall),
				.step(stage_step[i]),
				.load(stage_load[i]),
				.load_val(sfr_wdata),
				.count_q(stage_count[i]),
				.wrap(stage_wrap[i])
			);
		end
	endgenerate

	// selected timebase: fraction steps, or a stage's overflow
	assign tb_step = stage_step[tb_sel];
	assign interval_inc = interval_q + 8'h01;
	assign hit = control_q[BIT_INTERVAL_EN] && tb_step &&
		(interval_inc == target_q);

	// control, target and interval counter
	always_comb begin
		control_d = control_q;
		target_d = target_q;
		interval_d = interval_q;
		if (wr_ctl) begin
			// reserved bits 6 and 7 are dropped and read as zero
			control_d = {2'b00, sfr_wdata[5:0]};
		end
		if (sfr_wr && is_addr(sfr_addr, ADDR_INTERVAL_TARGET)) begin
			target_d = sfr_wdata;
		end
		if (!control_q[BIT_INTERVAL_EN]) begin
			interval_d = 8'h00;
		end else if (hit) begin
			interval_d = 8'h00;
			// a control write in the same cycle keeps the written enable
			if (control_q[BIT_ONE_SHOT] && !wr_ctl) begin
				control_d[BIT_INTERVAL_EN] = 1'b0;
			end
		end else if (tb_step) begin
			interval_d = interval_inc;
		end
		// a match in the clearing cycle must not be lost
		if (hit) begin
			control_d[BIT_MATCH_FLAG] = 1'b1;
		end
	end

	// read mux and status outputs
	always_comb begin
		rdata_d = sfr_rdata_q;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_TIMER_CONTROL: rdata_d = control_q;
				ADDR_FRACTION: rdata_d = stage_count[0];
				ADDR_ONE_HZ: rdata_d = stage_count[1];
				ADDR_SIXTY_SECOND: rdata_d = stage_count[2];
				ADDR_HOUR: rdata_d = stage_count[3];
				ADDR_INTERVAL_TARGET: rdata_d = target_q;
				default: rdata_d = 8'h00;
			endcase
		end
		irq_d = control_q[BIT_MATCH_FLAG] && intv_irq_en;
		wake_d = irq_d && power_down;
		vector_d = wake_d ? WAKE_VECTOR : 16'h0000;
	end

	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			control_q <= RST_TIMER_CONTROL;
			target_q <= RST_INTERVAL_TARGET;
			interval_q <= 8'h00;
			prescale_q <= 8'h00;
			sfr_rdata_q <= 8'h00;
			irq_q <= 1'b0;
			wake_q <= 1'b0;
			wake_vector_q <= 16'h0000;
		end else begin
			control_q <= control_d;
			target_q <= target_d;
			interval_q <= interval_d;
			prescale_q <= prescale_d;
			sfr_rdata_q <= rdata_d;
			irq_q <= irq_d;
			wake_q <= wake_d;
			wake_vector_q <= vector_d;
		end
	end
endmodule : citr_top

/* citr_top_chk.sv */
// port checker for the interval timer block
// assumes a bind from the bench; sees only top-level ports
`timescale 1ns/1ps
module citr_top_chk (
	input wire logic mclk, // clock
	input wire logic rst, // sync reset
	input wire logic intv_irq_en, // irq enable
	input wire logic power_down, // sleep level
	input wire logic [7:0] sfr_addr, // address
	input wire logic sfr_rd, // read strobe
	input wire logic [7:0] sfr_rdata_q, // read data
	input wire logic irq_q, // irq level
	input wire logic wake_q, // wake level
	input wire logic [15:0] wake_vector_q // wake vector
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// a control read; reserved bits must come back clear
	sequence s_rd_ctl;
		sfr_rd && sfr_addr == 8'ha1;
	endsequence
	sequence s_rd_hole;
		sfr_rd && (sfr_addr < 8'ha1 || sfr_addr > 8'ha6);
	endsequence
	a_ctl_reserved: assert property (
		s_rd_ctl |=> sfr_rdata_q[7:6] == 2'b00)
		else $error("reserved control bits read nonzero");
	a_unmapped_zero: assert property (s_rd_hole |=> sfr_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
		else $error("read data moved without a read");
	a_irq_needs_en: assert property (irq_q |-> $past(intv_irq_en))
		else $error("irq without enable");
	a_irq_drops: assert property (!intv_irq_en |=> !irq_q)
		else $error("irq stays after disable");
	a_wake_cause: assert property (
		wake_q |-> irq_q && $past(power_down))
		else $error("wake without irq in power-down");
	a_wake_vector: assert property (
		wake_q |-> wake_vector_q == 16'h0053)
		else $error("wrong wake vector");
	a_vector_idle: assert property (
		!wake_q |-> wake_vector_q == 16'h0000)
		else $error("vector shown without wake");
endmodule : citr_top_chk

/* citr_core_model.sv */
// core-side model: sfr strobes and the crystal tick
// assumes the bench calls acc; signals move at falling mclk
`timescale 1ns/1ps
module citr_core_model (
	input wire logic mclk, // clock
	output logic [7:0] addr, // sfr address
	output logic [7:0] wdata, // write data
	output logic wr, // write strobe
	output logic rd, // read strobe
	output logic tick // crystal tick
);
	// tick every cycle keeps a wrap within a few hundred cycles
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		tick = 1'b1;
	end
	// one-cycle strobe; read data is settled at the closing fall
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(negedge mclk);
		wr = 1'b0;
		rd = 1'b0;
	endtask : acc
endmodule : citr_core_model

/* citr_top_tb.sv */
// self-checking bench for the interval timer block
// assumes the core model drives sfr strobes and tick
`timescale 1ns/1ps
module citr_top_tb;
	import citr_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, power_down = 1'b0, intv_irq_en = 1'b0;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, t;
	logic sfr_wr, sfr_rd, xtal_tick, irq_q, wake_q;
	logic [15:0] wake_vector_q;
	int n_errors = 0, checks = 0, cyc = 0, seed = 32'hc32109af;
	always #12.5 mclk = ~mclk;
	citr_top i_dut (.mclk, .rst, .xtal_tick, .power_down, .intv_irq_en,
		.sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q, .irq_q,
		.wake_q, .wake_vector_q);
	citr_core_model i_core (.mclk, .addr(sfr_addr), .wdata(sfr_wdata),
		.wr(sfr_wr), .rd(sfr_rd), .tick(xtal_tick));
	function automatic logic [7:0] ctl(input logic [1:0] tb,
		input logic os, fl, ie, ce);
		return {2'b00, tb, os, fl, ie, ce};
	endfunction : ctl
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		i_core.acc(1'b0, a, 8'h00);
		cmp("sfr read", {8'h00, e}, {8'h00, sfr_rdata_q});
	endtask : rdc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_core.acc(1'b1, a, d);
	endtask : wr
	// stop and clear the chain first so the prescaler starts from zero
	task automatic start(input logic [7:0] c);
		wr(ADDR_TIMER_CONTROL, 8'h40);
		rdc(ADDR_FRACTION, 8'h00);
		wr(ADDR_TIMER_CONTROL, c | 8'h40);
	endtask : start
	// fraction preset to its last value, seconds as given, target one
	task automatic tb_case(input logic [1:0] tb, input logic [7:0] s,
		input logic e);
		wr(ADDR_TIMER_CONTROL, 8'h40);
		wr(ADDR_FRACTION, 8'h7f);
		wr(ADDR_ONE_HZ, s);
		wr(ADDR_INTERVAL_TARGET, 8'h01);
		wr(ADDR_TIMER_CONTROL, ctl(tb, 1'b0, 1'b0, 1'b1, 1'b1) | 8'h40);
		repeat (262) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, ctl(tb, 1'b0, e, 1'b1, 1'b1));
	endtask : tb_case
	task automatic tally_and_finish;
		if (n_errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// hang guard; the run needs about 4000 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		@(negedge mclk) rst = 1'b0;
		for (int a = 8'ha0; a < 8'ha8; a++) rdc(8'(a), 8'h00);
		t = 8'($random(seed));
		wr(ADDR_INTERVAL_TARGET, t);
		rdc(ADDR_INTERVAL_TARGET, t);
		wr(ADDR_TIMER_CONTROL, 8'hc0);
		rdc(ADDR_TIMER_CONTROL, 8'h00);
		// preload one step before midnight; hours timebase, target 1
		for (int a = 2; a < 6; a++) begin
			wr(8'ha0 + 8'(a), a == 2 ? 8'h7f : a == 5 ? 8'h17 : 8'h3b);
		end
		rdc(ADDR_HOUR, 8'h17);
		wr(ADDR_INTERVAL_TARGET, 8'h01);
		intv_irq_en = 1'b1;
		power_down = 1'b1;
		wr(ADDR_TIMER_CONTROL, ctl(2'b11, 1'b0, 1'b0, 1'b1, 1'b1) | 8'h40);
		repeat (262) @(negedge mclk);
		cmp("irq", 16'h0001, {15'h0, irq_q});
		cmp("wake vector", WAKE_VECTOR, wake_vector_q);
		cmp("wake", 16'h0001, {15'h0, wake_q});
		for (int a = 8'ha2; a < 8'ha6; a++) rdc(8'(a), 8'h00);
		rdc(ADDR_TIMER_CONTROL, ctl(2'b11, 1'b0, 1'b1, 1'b1, 1'b1));
		intv_irq_en = 1'b0;
		power_down = 1'b0;
		// single shot of two fraction steps drops the interval enable
		wr(ADDR_INTERVAL_TARGET, 8'h02);
		start(ctl(2'b00, 1'b1, 1'b0, 1'b1, 1'b1));
		repeat (520) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, ctl(2'b00, 1'b1, 1'b1, 1'b0, 1'b1));
		rdc(ADDR_FRACTION, 8'h02);
		// auto reload: flag again after a second interval
		t = 8'h01 + 8'($unsigned($random(seed)) % 2);
		wr(ADDR_INTERVAL_TARGET, t);
		start(ctl(2'b00, 1'b0, 1'b0, 1'b1, 1'b1));
		repeat (int'(t) * 256 + 8) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, ctl(2'b00, 1'b0, 1'b1, 1'b1, 1'b1));
		wr(ADDR_TIMER_CONTROL, 8'h43);
		rdc(ADDR_TIMER_CONTROL, 8'h03);
		repeat (int'(t) * 256) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, ctl(2'b00, 1'b0, 1'b1, 1'b1, 1'b1));
		// only the chosen stage's overflow may step the interval counter
		tb_case(2'b01, 8'h00, 1'b1);
		tb_case(2'b10, 8'h00, 1'b0);
		tb_case(2'b10, 8'h3b, 1'b1);
		tb_case(2'b11, 8'h3b, 1'b0);
		// a disabled counter restarts from zero: target 2 needs two steps
		wr(ADDR_INTERVAL_TARGET, 8'h02);
		start(8'h03);
		repeat (300) @(negedge mclk);
		wr(ADDR_TIMER_CONTROL, 8'h41);
		wr(ADDR_TIMER_CONTROL, 8'h43);
		repeat (220) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, 8'h03);
		repeat (256) @(negedge mclk);
		rdc(ADDR_TIMER_CONTROL, 8'h07);
		tally_and_finish();
	end
endmodule : citr_top_tb
bind citr_top citr_top_chk i_chk (.mclk, .rst, .intv_irq_en, .power_down,
	.sfr_addr, .sfr_rd, .sfr_rdata_q, .irq_q, .wake_q, .wake_vector_q);
